// >>> logic/sfs_regs.vh
// register layout, opcodes and reset values of the serial flash status block
`ifndef SFS_REGS_VH
`define SFS_REGS_VH

// ==========================================================
// opcodes
`define SFS_OP_READ_STATUS   8'h05
`define SFS_OP_WRITE_STAT1   8'h01
`define SFS_OP_WRITE_STAT2   8'h31
`define SFS_OP_RESET_ENABLE  8'hF0

// ==========================================================
// status byte one fields
`define SFS_S1_LOCK_BIT      7
`define SFS_S1_RSV_BIT       6
`define SFS_S1_EPE_BIT       5
`define SFS_S1_WPP_BIT       4
`define SFS_S1_SWP_HI        3
`define SFS_S1_SWP_LO        2
`define SFS_S1_WEL_BIT       1
`define SFS_RDY_BIT          0

// ==========================================================
// status byte two fields
`define SFS_S2_RESET_CMD_ENABLE_BIT      4
`define SFS_S2_SLE_BIT       3

// ==========================================================
// reset values
`define SFS_LOCK_RST         1'b0
`define SFS_RESET_CMD_ENABLE_RST         1'b0
`define SFS_SLE_RST          1'b0
`define SFS_WEL_RST          1'b0
`define SFS_SWP_RST          2'h3
`define SFS_SWP_RSVD         2'h2

// ==========================================================
// bit counts
`define SFS_BITS_PER_BYTE    4'h8

`endif

// >>> logic/sfs_sync.v
// two flip-flop synchroniser for pin inputs
`timescale 1ns/1ps
module sfs_sync #(
    parameter RST_VAL = 1'b0
) (
    input  wire clk,   // system clock
    input  wire rst,   // synchronous reset
    input  wire d_in,  // asynchronous input
    output reg  q_out  // synchronised level
);
    reg meta_ff;

    always @(posedge clk) begin
        if (rst) begin
            meta_ff <= RST_VAL;
            q_out   <= RST_VAL;
        end else begin
            meta_ff <= d_in;
            q_out   <= meta_ff;
        end
    end
endmodule // sfs_sync

// >>> logic/sfs_edge.v
// edge finder for the synchronised serial clock
`timescale 1ns/1ps
module sfs_edge (
    input  wire clk,    // system clock
    input  wire rst,    // synchronous reset
    input  wire lvl,    // synchronised level
    output wire rise,   // one-cycle rising pulse
    output wire fall    // one-cycle falling pulse
);
    reg last_ff;

    always @(posedge clk) begin
        if (rst) begin
            last_ff <= 1'b0;
        end else begin
            last_ff <= lvl;
        end
    end

    assign rise = lvl & ~last_ff;
    assign fall = ~lvl & last_ff;
endmodule // sfs_edge

// >>> logic/sfs_status.v
// status register pair with spi slave read and write commands
`timescale 1ns/1ps
`include "sfs_regs.vh"

// How it works
// - status read is served at any time, busy or not.
// - host selects, sends opcode 05h; status then shifts out every clock.
// - after byte two, output restarts with byte one while clocks continue.
// - each repeated byte is loaded from live status, no snapshot.
// - ready/busy sits in bit 0 of both bytes, refreshed per byte.
// - chip select high ends the read at once and floats output.
// - byte one bit 7 is the lock flag, zero after reset.
// - reserved bits read zero and ignore writes.
// - byte one bit 5 is the read-only program/erase error flag.
// - byte one bit 4 reads zero while write-protect pin is asserted.
// - byte one bits 3:2 show software protection, reset value 11.
// - byte one bit 1 shows write enable latch, read-only.
// - ready/busy reads one while an internal operation runs.
// - byte two bit 4 is reset-command enable, zero after reset.
// - byte two bit 3 is lockdown enable, zero after reset.
// - writing byte one changes only bit 7.
// - writing byte two changes only bits 4 and 3.
// - with write-protect asserted the lock flag may only be set.
// - error flag updates per operation, not on an aborted one.
// - write enable latch clears after power-up and reset.
// - software reset leaves reset-command enable unchanged.
module sfs_status (
    input  wire       clk,          // 125 MHz system clock
    input  wire       rst,          // synchronous reset, active high
    input  wire       sck,          // spi serial clock pin
    input  wire       cs_n,         // spi chip select pin, active low
    input  wire       si,           // spi serial data in pin
    input  wire       wp_n,         // write-protect pin, active low
    input  wire       busy,         // internal operation in progress
    input  wire       op_done,      // pulse: program or erase finished
    input  wire       op_fail,      // with op_done: verify failed
    input  wire       op_abort,     // with op_done: operation aborted
    input  wire [1:0] swp_state,    // software protection summary
    input  wire       wel_set,      // pulse: write enable command
    input  wire       wel_clr,      // pulse: write disable or completion
    output reg        so,           // serial data out
    output reg        so_oe,        // serial output enable
    output reg        prot_lock,    // lock flag to protection logic
    output reg        rst_cmd_en,   // reset-command enable
    output reg        lockdn_en,    // lockdown commands enable
    output reg        soft_rst      // pulse: software reset accepted
);

    // ======================================================
    // pin synchronisers and clock edges
    wire sck_s;
    wire cs_n_s;
    wire si_s;
    wire wp_n_s;
    wire sck_rise;
    wire sck_fall;

    sfs_sync #(.RST_VAL(1'b0)) u_sck (
        .clk   (clk),
        .rst   (rst),
        .d_in  (sck),
        .q_out (sck_s)
    );
    sfs_sync #(.RST_VAL(1'b1)) u_cs (
        .clk   (clk),
        .rst   (rst),
        .d_in  (cs_n),
        .q_out (cs_n_s)
    );
    sfs_sync #(.RST_VAL(1'b0)) u_si (
        .clk   (clk),
        .rst   (rst),
        .d_in  (si),
        .q_out (si_s)
    );
    sfs_sync #(.RST_VAL(1'b1)) u_wp (
        .clk   (clk),
        .rst   (rst),
        .d_in  (wp_n),
        .q_out (wp_n_s)
    );
    sfs_edge u_edge (
        .clk  (clk),
        .rst  (rst),
        .lvl  (sck_s),
        .rise (sck_rise),
        .fall (sck_fall)
    );

    // ======================================================
    // state machine
    localparam ST_OPCODE = 2'h0;
    localparam ST_READ   = 2'h1;
    localparam ST_WDATA  = 2'h2;
    localparam ST_IGNORE = 2'h3;

    reg [1:0] state_ff;
    reg [1:0] nxt_state;
    reg [7:0] shin_ff;
    reg [7:0] nxt_shin;
    reg [3:0] bitcnt_ff;
    reg [3:0] nxt_bitcnt;
    reg [7:0] opc_ff;
    reg [7:0] nxt_opc;
    reg [7:0] shout_ff;
    reg [7:0] nxt_shout;
    reg       byte_sel_ff;
    reg       nxt_byte_sel;
    reg       rst_armed_ff;
    reg       nxt_rst_armed;

    // status bits kept here
    reg       epe_ff;
    reg       wel_ff;

    wire      sel = ~cs_n_s;
    wire      wr_strobe;
    wire [7:0] wr_byte;

    // ======================================================
    // live status assembly
    function [7:0] stat_one;
        input       lock;
        input       prog_erase_error;
        input       wpn;
        input [1:0] soft_protect_state;
        input       write_enable_latch;
        input       bsy;
        begin
            stat_one = 8'h00;
            stat_one[`SFS_S1_LOCK_BIT] = lock;
            stat_one[`SFS_S1_EPE_BIT]  = prog_erase_error;
            stat_one[`SFS_S1_WPP_BIT]  = wpn;
            stat_one[`SFS_S1_SWP_HI:`SFS_S1_SWP_LO] = soft_protect_state;
            stat_one[`SFS_S1_WEL_BIT]  = write_enable_latch;
            stat_one[`SFS_RDY_BIT]     = bsy;
        end
    endfunction

    function [7:0] stat_two;
        input reset_cmd_enable;
        input lockdown_enable;
        input bsy;
        begin
            stat_two = 8'h00;
            stat_two[`SFS_S2_RESET_CMD_ENABLE_BIT] = reset_cmd_enable;
            stat_two[`SFS_S2_SLE_BIT]  = lockdown_enable;
            stat_two[`SFS_RDY_BIT]     = bsy;
        end
    endfunction

    wire [7:0] live_one = stat_one(prot_lock, epe_ff, wp_n_s, swp_state,
                                   wel_ff, busy);
    wire [7:0] live_two = stat_two(rst_cmd_en, lockdn_en, busy);

    // ======================================================
    // command sequencing
    always @* begin
        nxt_state     = state_ff;
        nxt_shin      = shin_ff;
        nxt_bitcnt    = bitcnt_ff;
        nxt_opc       = opc_ff;
        nxt_shout     = shout_ff;
        nxt_byte_sel  = byte_sel_ff;
        nxt_rst_armed = rst_armed_ff;
        if (!sel) begin
            nxt_state    = ST_OPCODE;
            nxt_bitcnt   = 4'h0;
            nxt_byte_sel = 1'b0;
            // armed reset fires once, on the first deselected cycle
            nxt_rst_armed = 1'b0;
        end else if (sck_rise) begin
            nxt_shin   = {shin_ff[6:0], si_s};
            nxt_bitcnt = bitcnt_ff + 4'h1;
            if (bitcnt_ff == `SFS_BITS_PER_BYTE - 4'h1) begin
                nxt_bitcnt = 4'h0;
                case (state_ff)
                    ST_OPCODE: begin
                        nxt_opc = {shin_ff[6:0], si_s};
                        if (nxt_opc == `SFS_OP_READ_STATUS) begin
                            nxt_state    = ST_READ;
                            nxt_shout    = live_one;
                            // opcode's own fall reloads byte one live
                            nxt_byte_sel = 1'b0;
                        end else if (nxt_opc == `SFS_OP_WRITE_STAT1 ||
                                     nxt_opc == `SFS_OP_WRITE_STAT2) begin
                            nxt_state = ST_WDATA;
                        end else begin
                            nxt_state = ST_IGNORE;
                        end
                    end
                    ST_WDATA: begin
                        nxt_state = ST_IGNORE;
                    end
                    default: begin
                        nxt_state = state_ff;
                    end
                endcase
            end
        end else if (sck_fall && state_ff == ST_READ) begin
            nxt_shout = {shout_ff[6:0], 1'b0};
            if (bitcnt_ff == 4'h0) begin
                nxt_shout    = byte_sel_ff ? live_two : live_one;
                nxt_byte_sel = ~byte_sel_ff;
            end
        end
        if (sel && sck_rise && state_ff == ST_OPCODE &&
            bitcnt_ff == `SFS_BITS_PER_BYTE - 4'h1) begin
            nxt_rst_armed = ({shin_ff[6:0], si_s} == `SFS_OP_RESET_ENABLE);
        end
    end

    // write data byte completes on this cycle
    assign wr_strobe = sel && sck_rise && state_ff == ST_WDATA &&
                       bitcnt_ff == `SFS_BITS_PER_BYTE - 4'h1 && wel_ff;
    assign wr_byte   = {shin_ff[6:0], si_s};

    always @(posedge clk) begin
        if (rst) begin
            state_ff     <= ST_OPCODE;
            shin_ff      <= 8'h00;
            bitcnt_ff    <= 4'h0;
            opc_ff       <= 8'h00;
            shout_ff     <= 8'h00;
            byte_sel_ff  <= 1'b0;
            rst_armed_ff <= 1'b0;
        end else begin
            state_ff     <= nxt_state;
            shin_ff      <= nxt_shin;
            bitcnt_ff    <= nxt_bitcnt;
            opc_ff       <= nxt_opc;
            shout_ff     <= nxt_shout;
            byte_sel_ff  <= nxt_byte_sel;
            rst_armed_ff <= nxt_rst_armed;
        end
    end

    // ======================================================
    // serial output
    always @(posedge clk) begin
        if (rst) begin
            so    <= 1'b0;
            so_oe <= 1'b0;
        end else begin
            // deselect floats the output at once
            so_oe <= sel && nxt_state == ST_READ;
            so    <= nxt_shout[7];
        end
    end

    // ======================================================
    // writable and hardware-updated bits
    always @(posedge clk) begin
        if (rst) begin
            prot_lock  <= `SFS_LOCK_RST;
            rst_cmd_en <= `SFS_RESET_CMD_ENABLE_RST;
            lockdn_en  <= `SFS_SLE_RST;
            epe_ff     <= 1'b0;
            wel_ff     <= `SFS_WEL_RST;
            soft_rst   <= 1'b0;
        end else begin
            soft_rst <= 1'b0;
            if (wr_strobe && opc_ff == `SFS_OP_WRITE_STAT1) begin
                // only bit 7 of byte one
                if (wp_n_s || wr_byte[`SFS_S1_LOCK_BIT]) begin
                    prot_lock <= wr_byte[`SFS_S1_LOCK_BIT];
                end
            end
            if (wr_strobe && opc_ff == `SFS_OP_WRITE_STAT2) begin
                // only bits 4 and 3 of byte two
                rst_cmd_en <= wr_byte[`SFS_S2_RESET_CMD_ENABLE_BIT];
                lockdn_en  <= wr_byte[`SFS_S2_SLE_BIT];
            end
            // aborted operations leave the flag alone
            if (op_done && !op_abort) begin
                epe_ff <= op_fail;
            end
            // reset command clears the latch; enables kept
            if (rst_armed_ff && !sel && rst_cmd_en) begin
                soft_rst <= 1'b1;
                wel_ff   <= 1'b0;
            end else if (wel_set) begin
                wel_ff <= 1'b1;
            end else if (wel_clr || wr_strobe) begin
                wel_ff <= 1'b0;
            end
        end
    end

endmodule // sfs_status

// >>> testbench/sfs_status_assertions.sv
// pin checker for the status block
`timescale 1ns/1ps
module sfs_chk (
    input wire clk,        // clock
    input wire rst,        // reset
    input wire sck,        // spi clock
    input wire cs_n,       // select
    input wire wp_n,       // protect pin
    input wire so,         // data out
    input wire so_oe,      // out enable
    input wire prot_lock,  // lock flag
    input wire rst_cmd_en, // reset enable
    input wire lockdn_en,  // lockdown enable
    input wire soft_rst    // reset pulse
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    // ====
    // sequences
    sequence s_idle;
        cs_n [*6];
    endsequence
    sequence s_shift;
        so_oe && $past(so_oe) && $changed(so);
    endsequence
    // ====
    // properties
    chk_idle_float: assert property (s_idle |-> !so_oe)
        else $error("output driven while deselected");
    chk_end_desel: assert property ($fell(so_oe) |-> $past(cs_n, 2))
        else $error("output dropped while selected");
    chk_start_sel: assert property ($rose(so_oe) |-> !cs_n && sck)
        else $error("output started off opcode end");
    chk_shift_low: assert property (s_shift |-> !sck && !cs_n)
        else $error("data moved while clock high");
    chk_lock_wp: assert property ($fell(prot_lock) |-> $past(wp_n, 4))
        else $error("lock cleared with pin asserted");
    chk_cfg_sel: assert property (($changed(rst_cmd_en) ||
        $changed(lockdn_en) || $changed(prot_lock)) |-> $past(!cs_n, 8))
        else $error("config changed outside a command");
    chk_srst_keep: assert property (soft_rst |->
        $stable(rst_cmd_en) && $stable(lockdn_en) && $stable(prot_lock))
        else $error("soft reset altered config");
    chk_srst_pulse: assert property (soft_rst |-> rst_cmd_en ##1 !soft_rst)
        else $error("bad soft reset pulse");
endmodule // sfs_chk

bind sfs_status sfs_chk u_chk (.clk(clk), .rst(rst), .sck(sck),
    .cs_n(cs_n), .wp_n(wp_n), .so(so), .so_oe(so_oe),
    .prot_lock(prot_lock), .rst_cmd_en(rst_cmd_en),
    .lockdn_en(lockdn_en), .soft_rst(soft_rst));

// >>> testbench/sfs_spi_host.sv
// spi host model for the status block
`timescale 1ns/1ps
module sfs_spi_host (
    input  wire       clk,     // system clock
    input  wire       so,      // device data out
    input  wire       so_oe,   // device out enable
    output reg        sck,     // spi clock, idle low
    output reg        cs_n,    // select
    output reg        si,      // data to device
    output reg  [7:0] rx_byte, // last byte read
    output reg        rx_vld   // result strobe
);
    // 80 ns half period keeps us under base rate
    localparam PH = 10;
    reg so_q = 1'b0;
    // floated line shows inverse of last level
    wire so_pin = so_oe ? so : ~so_q;
    initial begin
        sck = 1'b0;
        cs_n = 1'b1;
        si = 1'b0;
        rx_byte = 8'h00;
        rx_vld = 1'b0;
    end
    task sel;
        begin
            cs_n <= 1'b0;
            repeat (PH) @(posedge clk);
        end
    endtask
    task desel;
        begin
            sck <= 1'b0;
            repeat (PH) @(posedge clk);
            cs_n <= 1'b1;
            si <= ~si;
            repeat (PH) @(posedge clk);
        end
    endtask
    task xfer(input [7:0] tx, input integer n, input chk);
        integer i;
        reg [7:0] r;
        begin
            r = 8'h00;
            for (i = 7; i > 7 - n; i = i - 1) begin
                sck <= 1'b0;
                si <= tx[i];
                repeat (PH) @(posedge clk);
                r = {r[6:0], so_pin};
                so_q = so_pin;
                sck <= 1'b1;
                repeat (PH) @(posedge clk);
            end
            rx_byte <= r;
            rx_vld <= chk;
            @(posedge clk);
            rx_vld <= 1'b0;
        end
    endtask
endmodule // sfs_spi_host

// >>> testbench/testbench.sv
// self-checking bench for the status block
`timescale 1ns/1ps
`include "sfs_regs.vh"
module testbench;
    reg        clk = 1'b0;
    reg        rst = 1'b1;
    reg        wp_n = 1'b1;
    reg        busy = 1'b0;
    reg        op_done = 1'b0;
    reg        op_fail = 1'b0;
    reg        op_abort = 1'b0;
    reg  [1:0] swp_state = 2'h3;
    reg        wel_set = 1'b0;
    reg        wel_clr = 1'b0;
    wire       sck, cs_n, si, so, so_oe, prot_lock;
    wire       rst_cmd_en, lockdn_en, soft_rst, rx_vld;
    wire [7:0] rx_byte;
    reg  [7:0] exp_q[$];
    reg        lock_m, fail_m, latch_m, rce_m, lde_m;
    integer    err_count = 0;
    integer    samples_checked = 0;
    integer    n_srst = 0;
    integer    seed = 32'h01c3f304;

    always #4 clk = ~clk;

    sfs_status dut (.clk(clk), .rst(rst), .sck(sck), .cs_n(cs_n), .si(si),
        .wp_n(wp_n), .busy(busy), .op_done(op_done), .op_fail(op_fail),
        .op_abort(op_abort), .swp_state(swp_state), .wel_set(wel_set),
        .wel_clr(wel_clr), .so(so), .so_oe(so_oe), .prot_lock(prot_lock),
        .rst_cmd_en(rst_cmd_en), .lockdn_en(lockdn_en), .soft_rst(soft_rst));
    sfs_spi_host host (.clk(clk), .so(so), .so_oe(so_oe), .sck(sck),
        .cs_n(cs_n), .si(si), .rx_byte(rx_byte), .rx_vld(rx_vld));

    function automatic [7:0] st1();
        st1 = {lock_m, 1'b0, fail_m, wp_n, swp_state, latch_m, busy};
    endfunction
    function automatic [7:0] st2();
        st2 = {3'h0, rce_m, lde_m, 2'h0, busy};
    endfunction
    task cmp(input [63:0] nm, input [7:0] e, input [7:0] g);
        begin
            samples_checked = samples_checked + 1;
            if (g !== e) begin
                err_count = err_count + 1;
                $display("BAD %0s exp %h got %h", nm, e, g);
            end
        end
    endtask
    task complete_run;
        begin
            $display("checked %0d bad %0d", samples_checked, err_count);
            if (err_count == 0 && samples_checked > 0)
                $display("All tests passed");
            else
                $display("Some tests failed");
            $finish;
        end
    endtask
    // ====
    // result watcher
    always @(posedge clk) begin
        if (soft_rst === 1'b1)
            n_srst = n_srst + 1;
        if (rx_vld === 1'b1) begin
            if (exp_q.size() == 0)
                exp_q.push_back(8'hXX);
            cmp("status", exp_q.pop_front(), rx_byte);
        end
    end
    // ====
    // stimulus
    task stir;
        reg [1:0] s;
        begin
            s = 2'($random(seed));
            busy <= s[0];
            swp_state <= s[1] ? 2'h3 : {1'b0, s[0]};
            @(posedge clk);
        end
    endtask
    // live status per byte, so stir before each
    task rd(input integer n);
        integer j;
        begin
            stir;
            exp_q.push_back(st1());
            host.sel;
            host.xfer(`SFS_OP_READ_STATUS, 8, 1'b0);
            for (j = 1; j <= n; j = j + 1) begin
                host.xfer(8'h00, 8, 1'b1);
                if (j < n) begin
                    stir;
                    exp_q.push_back(j[0] ? st2() : st1());
                end
            end
            host.desel;
        end
    endtask
    task op(input f, input a);
        begin
            op_done <= 1'b1;
            op_fail <= f;
            op_abort <= a;
            @(posedge clk);
            op_done <= 1'b0;
            if (!a)
                fail_m = f;
        end
    endtask
    task we(input s);
        begin
            wel_set <= s;
            wel_clr <= !s;
            @(posedge clk);
            wel_set <= 1'b0;
            wel_clr <= 1'b0;
            latch_m = s;
        end
    endtask
    task wr(input [7:0] op, input [7:0] d);
        begin
            host.sel;
            host.xfer(op, 8, 1'b0);
            host.xfer(d, 8, 1'b0);
            host.desel;
            if (latch_m && op == `SFS_OP_WRITE_STAT1 && (wp_n || d[7]))
                lock_m = d[7];
            if (latch_m && op == `SFS_OP_WRITE_STAT2) begin
                rce_m = d[4];
                lde_m = d[3];
            end
            latch_m = 1'b0;
            cmp("levels", {5'h0, lock_m, rce_m, lde_m},
                {5'h0, prot_lock, rst_cmd_en, lockdn_en});
        end
    endtask
    task hw_reset;
        begin
            rst <= 1'b1;
            repeat (4) @(posedge clk);
            rst <= 1'b0;
            lock_m = 1'b0;
            fail_m = 1'b0;
            latch_m = 1'b0;
            rce_m = 1'b0;
            lde_m = 1'b0;
            repeat (4) @(posedge clk);
        end
    endtask
    initial begin
        hw_reset;
        rd(4);
        op(1'b1, 1'b1);
        rd(2);
        op(1'b1, 1'b0);
        rd(3);
        op(1'b0, 1'b0);
        rd(2);
        wr(`SFS_OP_WRITE_STAT1, 8'hFF);
        we(1'b1);
        rd(1);
        wr(`SFS_OP_WRITE_STAT1, 8'hFF);
        we(1'b1);
        wr(`SFS_OP_WRITE_STAT2, 8'hFF);
        rd(4);
        wp_n <= 1'b0;
        we(1'b1);
        wr(`SFS_OP_WRITE_STAT1, 8'h00);
        rd(2);
        wp_n <= 1'b1;
        we(1'b1);
        wr(`SFS_OP_WRITE_STAT1, 8'h00);
        wp_n <= 1'b0;
        we(1'b1);
        wr(`SFS_OP_WRITE_STAT1, 8'h80);
        wp_n <= 1'b1;
        we(1'b1);
        host.sel;
        host.xfer(`SFS_OP_RESET_ENABLE, 8, 1'b0);
        host.desel;
        latch_m = 1'b0;
        cmp("srst", 8'h01, n_srst[7:0]);
        rd(2);
        host.sel;
        host.xfer(`SFS_OP_READ_STATUS, 8, 1'b0);
        host.xfer(8'h00, 3, 1'b0);
        host.desel;
        rd(3);
        hw_reset;
        rd(2);
        cmp("queue", 8'h00, 8'(exp_q.size()));
        complete_run;
    end
    initial begin
        repeat (100000) @(posedge clk);
        err_count = err_count + 1;
        complete_run;
    end
endmodule // testbench
